// [hdl/supervisor_output_margin_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_params.svh"
// What this block does
// - margin low freezes all three outputs
// - margin overrides manual reset
// - three active-low open-drain outputs
// - reset and alarm held until timers expire
// - any overvoltage flag asserts alarm
// - alarm released after 25us flag-free
// - undriven margin reads as inactive
// - undervoltage or manual reset asserts reset
// - reset held 200ms after causes clear
// - watchdog timeouts 102.4s then 1.6s
// - expiry asserts, any kick edge releases
module supervisor_output_margin_ctrl #(
   parameter int NUM_CH = `NUM_CH_DEF,
   parameter longint RST_HOLD = `RST_HOLD_CYC,
   parameter longint OV_HOLD = `OV_HOLD_CYC,
   parameter longint WD_INIT = `WD_INIT_CYC,
   parameter longint WD_NORM = `WD_NORM_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire supervisor_pkg::ch_flags_t [NUM_CH-1:0] ch_flags,
   input wire logic manual_reset_n,
   input wire logic margin_hold_n,
   input wire logic watchdog_kick,
   output supervisor_pkg::od_pin_t sys_reset_n,
   output supervisor_pkg::od_pin_t overvolt_alarm_n,
   output supervisor_pkg::od_pin_t watchdog_expired_n
);
   localparam int CW = 40;

   // elaboration check on channel count and counter width
   if (!(NUM_CH == 4 || NUM_CH == 6)) begin : g_bad_ch
      $error("NUM_CH must be 4 or 6");
   end
   if (WD_INIT >= (64'd1 << CW) || RST_HOLD < 1 || OV_HOLD < 1 || WD_NORM < 1) begin : g_bad_cnt
      $error("counts out of range");
   end

   // two-stage synchronisers for all pin inputs; second stage is read, plus a delayed copy of it for the kick edge
   logic [NUM_CH-1:0] uv_s1, uv_s2, ov_s1, ov_s2;
   logic mr_s1, mr_s2, mg_s1, mg_s2, kick_s1, kick_s2, kick_d;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         uv_s1 <= '0;
         uv_s2 <= '0;
         ov_s1 <= '0;
         ov_s2 <= '0;
         mr_s1 <= 1'b1;
         mr_s2 <= 1'b1;
         mg_s1 <= 1'b1;
         mg_s2 <= 1'b1;
         kick_s1 <= 1'b0;
         kick_s2 <= 1'b0;
         kick_d <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            uv_s1[i] <= ch_flags[i].uv;
            ov_s1[i] <= ch_flags[i].ov;
         end
         uv_s2 <= uv_s1;
         ov_s2 <= ov_s1;
         mr_s1 <= manual_reset_n;
         mr_s2 <= mr_s1;
         mg_s1 <= margin_hold_n;
         mg_s2 <= mg_s1;
         kick_s1 <= watchdog_kick;
         kick_s2 <= kick_s1;
         kick_d <= kick_s2;
      end
   end

   logic frozen, rst_cause, ov_cause, kick_edge;
   assign frozen = !mg_s2;
   assign rst_cause = (|uv_s2) || !mr_s2;
   assign ov_cause = |ov_s2;
   assign kick_edge = kick_s2 ^ kick_d;

   // reset hold counter; power-on starts with reset asserted and full hold
   logic [CW-1:0] rst_cnt;
   logic rst_act;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_cnt <= CW'(RST_HOLD);
         rst_act <= 1'b1;
      end else if (!frozen) begin
         if (rst_cause) begin
            rst_cnt <= CW'(RST_HOLD);
            rst_act <= 1'b1;
         end else if (rst_cnt > CW'(1)) begin
            rst_cnt <= rst_cnt - CW'(1);
         end else begin
            rst_cnt <= '0;
            rst_act <= 1'b0;
         end
      end
   end

   // overvoltage alarm hold, restarted by any flag
   logic [CW-1:0] ov_cnt;
   logic ov_act;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ov_cnt <= CW'(OV_HOLD);
         ov_act <= 1'b1;
      end else if (!frozen) begin
         if (ov_cause) begin
            ov_cnt <= CW'(OV_HOLD);
            ov_act <= 1'b1;
         end else if (ov_cnt > CW'(1)) begin
            ov_cnt <= ov_cnt - CW'(1);
         end else begin
            ov_cnt <= '0;
            ov_act <= 1'b0;
         end
      end
   end

   // watchdog: cleared while reset is asserted; initial period after release
   // a kick edge while frozen is lost: neither the count nor expiry can change
   logic [CW-1:0] wd_cnt;
   logic wd_exp;
   supervisor_pkg::wd_phase_t wd_phase;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wd_cnt <= CW'(WD_INIT);
         wd_exp <= 1'b0;
         wd_phase <= supervisor_pkg::WD_INITIAL;
      end else if (!frozen) begin
         if (rst_act) begin
            wd_cnt <= CW'(WD_INIT);
            wd_exp <= 1'b0;
            wd_phase <= supervisor_pkg::WD_INITIAL;
         end else if (wd_exp) begin
            if (kick_edge) begin
               wd_exp <= 1'b0;
               wd_cnt <= CW'(WD_INIT);
               wd_phase <= supervisor_pkg::WD_INITIAL;
            end
         end else if (kick_edge) begin
            wd_cnt <= CW'(WD_NORM);
            wd_phase <= supervisor_pkg::WD_NORMAL;
         end else if (wd_cnt > CW'(1)) begin
            wd_cnt <= wd_cnt - CW'(1);
         end else begin
            wd_exp <= 1'b1;
            wd_cnt <= '0;
         end
      end
   end

   // open-drain pins: output held low, enable pulls the wire down
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_reset_n <= '{o: 1'b0, oe: 1'b1};
         overvolt_alarm_n <= '{o: 1'b0, oe: 1'b1};
         watchdog_expired_n <= '{o: 1'b0, oe: 1'b0};
      end else begin
         sys_reset_n <= '{o: 1'b0, oe: rst_act};
         overvolt_alarm_n <= '{o: 1'b0, oe: ov_act};
         watchdog_expired_n <= '{o: 1'b0, oe: wd_exp};
      end
   end

   a_freeze_reset: assert property (@(posedge clk) disable iff (!rst_b)
      frozen && $past(frozen) |-> $stable(rst_act))
      else $error("reset changed while margin held");
   a_freeze_ovwd: assert property (@(posedge clk) disable iff (!rst_b)
      frozen && $past(frozen) |-> $stable(ov_act) && $stable(wd_exp))
      else $error("alarm or expiry changed while margin held");
   a_margin_mr: assert property (@(posedge clk) disable iff (!rst_b)
      $past(frozen) && !$past(rst_act) |-> !rst_act)
      else $error("manual reset passed through margin");
   a_od_low: assert property (@(posedge clk) disable iff (!rst_b)
      !sys_reset_n.o && !overvolt_alarm_n.o && !watchdog_expired_n.o)
      else $error("open-drain pin driven high");
   a_ov_assert: assert property (@(posedge clk) disable iff (!rst_b)
      ov_cause && !frozen |=> ov_act ##1 overvolt_alarm_n.oe)
      else $error("alarm not asserted on flag");
   a_ov_hold: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(ov_cause) && !frozen |-> ov_act [*8])
      else $error("alarm released early");
   a_rst_assert: assert property (@(posedge clk) disable iff (!rst_b)
      rst_cause && !frozen |=> rst_act && rst_cnt == CW'(RST_HOLD))
      else $error("reset not asserted on cause");
   a_rst_hold: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(rst_act) |-> $past(rst_cnt) == CW'(1) && !$past(rst_cause))
      else $error("reset released before hold ran out");
   a_wd_release: assert property (@(posedge clk) disable iff (!rst_b)
      wd_exp && kick_edge && !frozen && !rst_act |=> !wd_exp && wd_cnt == CW'(WD_INIT))
      else $error("expiry not released on kick edge");
   a_wd_normal: assert property (@(posedge clk) disable iff (!rst_b)
      !wd_exp && kick_edge && !frozen && !rst_act |=> wd_cnt == CW'(WD_NORM))
      else $error("normal timeout not loaded");
   // watchdog clearing during reset, phase entry and expiry, end of the alarm hold, and the reset pin pulled low on a cause
   a_wd_cleared: assert property (@(posedge clk) disable iff (!rst_b)
      rst_act && !frozen |=> !wd_exp && wd_phase == supervisor_pkg::WD_INITIAL && wd_cnt == CW'(WD_INIT))
      else $error("watchdog not cleared during reset");
   a_wd_phase: assert property (@(posedge clk) disable iff (!rst_b)
      !wd_exp && kick_edge && !frozen && !rst_act |=> wd_phase == supervisor_pkg::WD_NORMAL)
      else $error("kick did not enter normal phase");
   a_wd_expire: assert property (@(posedge clk) disable iff (!rst_b)
      !wd_exp && !kick_edge && !frozen && !rst_act && wd_cnt == CW'(1) |=> wd_exp ##1 watchdog_expired_n.oe)
      else $error("expiry not asserted at timeout");
   a_ov_release: assert property (@(posedge clk) disable iff (!rst_b)
      ov_act && !ov_cause && !frozen && ov_cnt == CW'(1) |=> !ov_act)
      else $error("alarm not released after hold");
   a_rst_pin: assert property (@(posedge clk) disable iff (!rst_b)
      rst_cause && !frozen |=> ##1 sys_reset_n.oe)
      else $error("reset pin not pulled low on cause");
   c_ov_event: cover property (@(posedge clk) disable iff (!rst_b) $fell(ov_act));
   c_rst_release: cover property (@(posedge clk) disable iff (!rst_b) $fell(rst_act));
   c_wd_expire: cover property (@(posedge clk) disable iff (!rst_b) $rose(wd_exp));
   c_margin_mr: cover property (@(posedge clk) disable iff (!rst_b) frozen && !mr_s2);
endmodule // supervisor_output_margin_ctrl
`default_nettype wire

// [hdl/supervisor_params.svh]
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH
// oscillator rate and documented intervals in their own units
`define CLK_FREQ_HZ 250000000
`define OV_HOLD_NS 25000
`define RST_HOLD_MS 200
`define WD_INIT_MS 102400
`define WD_NORM_MS 1600
// cycle counts: hold times are least times, rounded up
`define OV_HOLD_CYC ((`OV_HOLD_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define RST_HOLD_CYC (`RST_HOLD_MS * (`CLK_FREQ_HZ / 1000))
`define WD_INIT_CYC (64'd`WD_INIT_MS * (`CLK_FREQ_HZ / 1000))
`define WD_NORM_CYC (64'd`WD_NORM_MS * (`CLK_FREQ_HZ / 1000))
`define NUM_CH_DEF 6
`endif

// [hdl/supervisor_pkg.sv]
package supervisor_pkg;
   // per-channel comparator flags travel together
   typedef struct packed {
      logic uv;
      logic ov;
   } ch_flags_t;
   // open-drain pin: drive low while oe is high
   typedef struct packed {
      logic o;
      logic oe;
   } od_pin_t;
   typedef enum logic [1:0] {
      WD_INITIAL = 2'b01,
      WD_NORMAL = 2'b10
   } wd_phase_t;
endpackage

// [sim/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// host that keeps the watchdog alive by toggling its kick line
module host_model #(
   parameter int PERIOD = 20
) (
   input wire logic clk,
   input wire logic kick_en,
   input wire logic poke,
   output var logic watchdog_kick
);
   int cnt = 0;
   logic level = 1'b0;
   assign watchdog_kick = level;
   // period stays well inside the normal timeout; poke gives one lone edge
   always @(posedge clk) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (poke || (kick_en && cnt == 0)) begin
         level <= ~level;
      end
   end
endmodule // host_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic mr_n = 1'b1;
   logic margin_low = 1'b0;
   logic kick_en = 1'b1;
   logic poke = 1'b0;
   logic [3:0] uv = 4'h0;
   logic [3:0] ov = 4'h0;
   int bad_count = 0;
   int total_checks = 0;
   tri1 margin_line;
   wire logic kick;
   supervisor_pkg::ch_flags_t [3:0] flags;
   supervisor_pkg::od_pin_t rst_pin, ov_pin, wd_pin;
   // each open-drain pin is pulled up outside the block
   wire logic rst_lvl = ~rst_pin.oe;
   wire logic ov_lvl = ~ov_pin.oe;
   wire logic wd_lvl = ~wd_pin.oe;
   logic ov_tie = 1'b0;
   // the system may wire the alarm pin into manual reset
   wire logic mr_line = mr_n & (ov_tie ? ov_lvl : 1'b1);
   assign margin_line = margin_low ? 1'b0 : 1'bz;
   always_comb for (int i = 0; i < 4; i++) flags[i] = '{uv: uv[i], ov: ov[i]};
   initial forever #2 clk = ~clk;
   supervisor_output_margin_ctrl #(.NUM_CH(4), .RST_HOLD(100), .OV_HOLD(20), .WD_INIT(500), .WD_NORM(50))
      supervisor_output_margin_ctrl_i (.clk(clk), .rst_b(rst_b), .ch_flags(flags), .manual_reset_n(mr_line),
      .margin_hold_n(margin_line), .watchdog_kick(kick), .sys_reset_n(rst_pin),
      .overvolt_alarm_n(ov_pin), .watchdog_expired_n(wd_pin));
   host_model host_model_i (.clk(clk), .kick_en(kick_en), .poke(poke), .watchdog_kick(kick));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: pin %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic t_power_up;
      cyc(20);
      rst_b = 1'b1;
      cyc(2);
      chk(rst_lvl, 1'b0);
      chk(ov_lvl, 1'b0);
      chk(rst_pin.o, 1'b0);
      chk(ov_pin.o, 1'b0);
      chk(wd_pin.o, 1'b0);
      chk(wd_lvl, 1'b1);
      cyc(30);
      chk(ov_lvl, 1'b1);
      cyc(60);
      chk(rst_lvl, 1'b0);
      cyc(20);
      chk(rst_lvl, 1'b1);
   endtask
   // a second fault inside the hold must restart it
   task automatic t_undervolt;
      uv = 4'h8;
      cyc(6);
      chk(rst_lvl, 1'b0);
      uv = 4'h0;
      cyc(90);
      uv = 4'h2;
      cyc(2);
      uv = 4'h0;
      cyc(90);
      chk(rst_lvl, 1'b0);
      cyc(20);
      chk(rst_lvl, 1'b1);
      mr_n = 1'b0;
      cyc(6);
      chk(rst_lvl, 1'b0);
      mr_n = 1'b1;
      cyc(112);
      chk(rst_lvl, 1'b1);
   endtask
   task automatic t_overvolt;
      ov = 4'h1;
      cyc(6);
      chk(ov_lvl, 1'b0);
      chk(rst_lvl, 1'b1);
      ov = 4'h0;
      cyc(15);
      ov = 4'h4;
      cyc(2);
      ov = 4'h0;
      cyc(15);
      chk(ov_lvl, 1'b0);
      cyc(12);
      chk(ov_lvl, 1'b1);
   endtask
   // alarm tied into manual reset: reset follows the alarm, then its own hold
   task automatic t_ov_tied;
      ov_tie = 1'b1;
      ov = 4'h8;
      cyc(10);
      chk(ov_lvl, 1'b0);
      chk(rst_lvl, 1'b0);
      ov = 4'h0;
      cyc(100);
      chk(rst_lvl, 1'b0);
      cyc(30);
      chk(rst_lvl, 1'b1);
      ov_tie = 1'b0;
   endtask
   // freeze both ways: faults ignored while pins released, clears ignored while pins asserted
   task automatic t_margin;
      margin_low = 1'b1;
      cyc(4);
      uv = 4'h1;
      mr_n = 1'b0;
      ov = 4'h2;
      cyc(20);
      chk(rst_lvl, 1'b1);
      chk(ov_lvl, 1'b1);
      margin_low = 1'b0;
      cyc(6);
      chk(rst_lvl, 1'b0);
      uv = 4'h0;
      mr_n = 1'b1;
      ov = 4'h0;
      margin_low = 1'b1;
      cyc(150);
      chk(rst_lvl, 1'b0);
      chk(ov_lvl, 1'b0);
      margin_low = 1'b0;
      cyc(130);
      chk(rst_lvl, 1'b1);
      chk(ov_lvl, 1'b1);
   endtask
   task automatic t_watchdog;
      kick_en = 1'b0;
      poke = 1'b1;
      cyc(1);
      poke = 1'b0;
      cyc(45);
      chk(wd_lvl, 1'b1);
      cyc(15);
      chk(wd_lvl, 1'b0);
      poke = 1'b1;
      cyc(1);
      poke = 1'b0;
      cyc(8);
      chk(wd_lvl, 1'b1);
      cyc(420);
      chk(wd_lvl, 1'b1);
      cyc(100);
      chk(wd_lvl, 1'b0);
      kick_en = 1'b1;
      cyc(30);
      chk(wd_lvl, 1'b1);
   endtask
   initial begin
      t_power_up;
      t_undervolt;
      t_overvolt;
      t_ov_tied;
      t_margin;
      t_watchdog;
      tally_and_finish;
   end
   initial begin
      repeat (4000) @(posedge clk);
      bad_count++;
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire
